// ---- masked_alu_map.vh ----
`ifndef MASKED_ALU_MAP_VH
`define MASKED_ALU_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_INSTR        8'h00
`define OFF_DEST         8'h04
`define OFF_SRC_REG      8'h08
`define OFF_FLAGS        8'h0C
`define OFF_STATUS       8'h10
`define OFF_RESULT       8'h14

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define INSTR_OP_HI      31
`define INSTR_OP_LO      26
`define EFF_WZ_BIT       25
`define EFF_WC_BIT       24
`define EFF_WR_BIT       23
`define EFF_IMM_BIT      22
`define COND_HI          21
`define COND_LO          18
`define DEST_HI          17
`define DEST_LO          9
`define SRC_HI           8
`define SRC_LO           0

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define OP_MASKED_COPY_INVERTED_CARRY     6'h1D
`define OP_MASKED_COPY_ZERO_FLAG          6'h1E
`define OP_MASKED_COPY_INVERTED_ZERO_FLAG 6'h1F
`define OP_ADDITIVE_INVERSE               6'h29
`define OP_CARRY_SELECTED_INVERSE         6'h2C

// ----------------------------------------------------------------
// flag and status bits, reset values, timing
// ----------------------------------------------------------------
`define FLAG_Z_BIT       0
`define FLAG_C_BIT       1
`define STAT_BUSY_BIT    0
`define STAT_DONE_BIT    1
`define STAT_ILLEGAL_BIT 2
`define STAT_WROTE_BIT   3
`define STAT_SKIPPED_BIT 4
`define RST_WORD         32'h0000_0000
`define RST_FLAGS        2'h0
`define EXEC_CLOCKS      4
`define EXEC_CNT_LAST    2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- masked_alu_core.v ----
`timescale 1ns/1ns
`include "masked_alu_map.vh"

module masked_alu_core (
    input  wire [5:0]  opcode,
    input  wire [31:0] dest_val,
    input  wire [31:0] operand,
    input  wire        z_flag,
    input  wire        c_flag,
    output reg  [31:0] result,
    output reg         z_new,
    output reg         c_new,
    output reg         known
);

    wire [31:0] negated;
    reg         fill_bit;
    reg         is_mask_op;

    // wraps naturally: the most negative value negates to itself
    assign negated = (~operand) + 32'h0000_0001;

    always @* begin
        fill_bit   = 1'b0;
        is_mask_op = 1'b1;
        known      = 1'b1;
        result     = dest_val;
        case (opcode)
            `OP_MASKED_COPY_INVERTED_CARRY: begin
                fill_bit = ~c_flag;
            end
            `OP_MASKED_COPY_INVERTED_ZERO_FLAG: begin
                fill_bit = ~z_flag;
            end
            `OP_MASKED_COPY_ZERO_FLAG: begin
                fill_bit = z_flag;
            end
            `OP_ADDITIVE_INVERSE: begin
                is_mask_op = 1'b0;
                result     = negated;
            end
            `OP_CARRY_SELECTED_INVERSE: begin
                is_mask_op = 1'b0;
                result     = c_flag ? negated : operand;
            end
            default: begin
                is_mask_op = 1'b0;
                known      = 1'b0;
            end
        endcase
        if (is_mask_op) begin
            // each 1 in the mask takes the chosen flag, others keep dest
            result = (dest_val & ~operand) | (operand & {32{fill_bit}});
        end
        z_new = (result == 32'h0000_0000);
        // mask ops give odd parity, negates give source sign
        c_new = is_mask_op ? (^result) : operand[31];
    end

endmodule

// ---- masked_alu.v ----
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "masked_alu_map.vh"

// Overview of operation
// - masked inverted-carry copy sets masked destination bits to not-carry, others kept.
// - masked inverted-zero copy sets masked destination bits to not-zero, others kept.
// - masked zero copy sets masked destination bits to the zero flag, others kept.
// - code 011111, effects 001i, condition 1111 decodes inverted-zero copy; four clocks.
// - code 011110, effects 001i, condition 1111 decodes zero copy; four clocks.
// - masked copies set zero on zero result, carry to result odd parity.
// - mask is a register or 9-bit literal; its ones select overwritten bits.
// - plain negate writes two's-complement negation of the source.
// - code 101001 decodes plain negate; zero on zero, carry from source bit 31.
// - carry-selected negate writes source when carry 0, its negation when 1.
// - code 101100 decodes carry-selected negate; zero on zero, carry source bit 31.
// - negating the most negative value returns it unchanged.
// - code 011101 decodes inverted-carry copy; zero flag, parity carry; four clocks.
// - result goes to destination unless the no-result effect is given.

module masked_alu (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_EXEC = 2'b01;

    reg  [1:0]  state_q;
    reg  [1:0]  cnt_q;
    reg  [31:0] instr_q;
    reg  [31:0] dest_q;
    reg  [31:0] src_reg_q;
    reg         z_q;
    reg         c_q;
    reg  [31:0] result_q;
    reg         done_q;
    reg         illegal_q;
    reg         wrote_q;
    reg         skipped_q;

    reg         aw_got_q;
    reg         w_got_q;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;

    wire [5:0]  opcode;
    wire        eff_wz;
    wire        eff_wc;
    wire        eff_wr;
    wire        eff_imm;
    wire [3:0]  cond;
    wire [31:0] operand;
    wire [31:0] alu_result;
    wire        alu_z;
    wire        alu_c;
    wire        alu_known;
    wire        cond_met;
    wire        busy;
    wire        commit;

    wire        wr_go;
    wire [7:0]  wr_addr;
    wire [7:0]  rd_addr;
    reg         wr_hit;
    reg         wr_refused;
    reg  [31:0] rd_word;
    reg         rd_hit;

    // ----------------------------------------------------------------
    // decode of the held instruction
    // ----------------------------------------------------------------
    assign opcode  = instr_q[`INSTR_OP_HI:`INSTR_OP_LO];
    assign eff_wz  = instr_q[`EFF_WZ_BIT];
    assign eff_wc  = instr_q[`EFF_WC_BIT];
    assign eff_wr  = instr_q[`EFF_WR_BIT];
    assign eff_imm = instr_q[`EFF_IMM_BIT];
    assign cond    = instr_q[`COND_HI:`COND_LO];

    // literal is zero-extended; otherwise the register value fed by software
    assign operand = eff_imm ? {23'h000000, instr_q[`SRC_HI:`SRC_LO]} : src_reg_q;

    // condition is a truth table indexed by {carry, zero}; 1111 always runs
    assign cond_met = cond[{c_q, z_q}];

    assign busy   = (state_q == ST_EXEC);
    assign commit = busy && (cnt_q == `EXEC_CNT_LAST);

    masked_alu_core u_core (
        .opcode   (opcode),
        .dest_val (dest_q),
        .operand  (operand),
        .z_flag   (z_q),
        .c_flag   (c_q),
        .result   (alu_result),
        .z_new    (alu_z),
        .c_new    (alu_c),
        .known    (alu_known)
    );

    // ----------------------------------------------------------------
    // bus write path
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    assign wr_go         = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_addr       = {awaddr_q[7:2], 2'b00};
    assign rd_addr       = {s_axi_araddr[7:2], 2'b00};

    function [31:0] merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    always @* begin
        wr_hit = 1'b1;
        if (wr_addr == `OFF_INSTR) begin
            wr_hit = 1'b1;
        end else if (wr_addr == `OFF_DEST) begin
            wr_hit = 1'b1;
        end else if (wr_addr == `OFF_SRC_REG) begin
            wr_hit = 1'b1;
        end else if (wr_addr == `OFF_FLAGS) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
        // operands stay frozen while an instruction is in flight
        wr_refused = !wr_hit || busy;
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= `RST_WORD;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_refused ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // operand, flag and execution state
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            cnt_q     <= 2'h0;
            instr_q   <= `RST_WORD;
            dest_q    <= `RST_WORD;
            src_reg_q <= `RST_WORD;
            z_q       <= 1'b0;
            c_q       <= 1'b0;
            result_q  <= `RST_WORD;
            done_q    <= 1'b0;
            illegal_q <= 1'b0;
            wrote_q   <= 1'b0;
            skipped_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_go && !wr_refused) begin
                        if (wr_addr == `OFF_INSTR) begin
                            // a write here launches execution of the word
                            instr_q   <= merge(instr_q, wdata_q, wstrb_q);
                            state_q   <= ST_EXEC;
                            cnt_q     <= 2'h0;
                            done_q    <= 1'b0;
                            illegal_q <= 1'b0;
                            wrote_q   <= 1'b0;
                            skipped_q <= 1'b0;
                        end else if (wr_addr == `OFF_DEST) begin
                            dest_q <= merge(dest_q, wdata_q, wstrb_q);
                        end else if (wr_addr == `OFF_SRC_REG) begin
                            src_reg_q <= merge(src_reg_q, wdata_q, wstrb_q);
                        end else if (wstrb_q[0]) begin
                            z_q <= wdata_q[`FLAG_Z_BIT];
                            c_q <= wdata_q[`FLAG_C_BIT];
                        end
                    end
                end
                ST_EXEC: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (commit) begin
                        state_q <= ST_IDLE;
                        done_q  <= 1'b1;
                        if (!alu_known) begin
                            illegal_q <= 1'b1;
                        end else if (!cond_met) begin
                            // condition false: nothing changes, time still spent
                            skipped_q <= 1'b1;
                        end else begin
                            result_q <= alu_result;
                            if (eff_wr) begin
                                dest_q  <= alu_result;
                                wrote_q <= 1'b1;
                            end
                            if (eff_wz) begin
                                z_q <= alu_z;
                            end
                            if (eff_wc) begin
                                c_q <= alu_c;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus read path
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        rd_hit  = 1'b1;
        rd_word = `RST_WORD;
        if (rd_addr == `OFF_INSTR) begin
            rd_word = instr_q;
        end else if (rd_addr == `OFF_DEST) begin
            rd_word = dest_q;
        end else if (rd_addr == `OFF_SRC_REG) begin
            rd_word = src_reg_q;
        end else if (rd_addr == `OFF_FLAGS) begin
            rd_word[`FLAG_Z_BIT] = z_q;
            rd_word[`FLAG_C_BIT] = c_q;
        end else if (rd_addr == `OFF_STATUS) begin
            rd_word[`STAT_BUSY_BIT]    = busy;
            rd_word[`STAT_DONE_BIT]    = done_q;
            rd_word[`STAT_ILLEGAL_BIT] = illegal_q;
            rd_word[`STAT_WROTE_BIT]   = wrote_q;
            rd_word[`STAT_SKIPPED_BIT] = skipped_q;
        end else if (rd_addr == `OFF_RESULT) begin
            rd_word = result_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `RST_WORD;
            s_axi_rresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- masked_alu_chk.sv ----
`timescale 1ns/1ns
`include "masked_alu_map.vh"

module masked_alu_chk (
    input wire        clk_sys,
    input wire        reset,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    // ----------------------------------------
    // bus response checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // only one write in flight, so the last taken address names the response
    reg [7:0] wa_q;
    always @(posedge clk_sys) begin
        if (reset)
            wa_q <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready)
            wa_q <= s_axi_awaddr;
    end

    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    chk_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    chk_aw_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    chk_ro_write: assert property ($rose(s_axi_bvalid) && wa_q >= `OFF_STATUS |->
        s_axi_bresp == `RESP_SLVERR)
        else $error("read-only write not refused");
    chk_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h18 |=>
        s_axi_rresp == `RESP_SLVERR && s_axi_rdata == `RST_WORD)
        else $error("unmapped read not refused");
    chk_good_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h18 |=>
        s_axi_rresp == `RESP_OKAY)
        else $error("mapped read refused");

    cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `RESP_SLVERR);
    cover property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OFF_INSTR);
endmodule

bind masked_alu masked_alu_chk u_chk (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// ---- axil_master_model.sv ----
`timescale 1ns/1ns

module axil_master_model (
    input  wire        clk_sys,
    output reg  [7:0]  awaddr = 8'h00,
    output reg         awvalid = 1'b0,
    input  wire        awready,
    output reg  [31:0] wdata = 32'h0,
    output wire [3:0]  wstrb,
    output reg         wvalid = 1'b0,
    input  wire        wready,
    input  wire [1:0]  bresp,
    input  wire        bvalid,
    output reg         bready = 1'b0,
    output reg  [7:0]  araddr = 8'h00,
    output reg         arvalid = 1'b0,
    input  wire        arready,
    input  wire [31:0] rdata,
    input  wire [1:0]  rresp,
    input  wire        rvalid,
    output reg         rready = 1'b0,
    output reg         hung = 1'b0
);
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    assign wstrb = 4'hF;

    // released lines flip so a stale value never looks valid
    task wr(input [7:0] a, input [31:0] d, output [1:0] resp);
        integer n;
        begin
            @(posedge clk_sys);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
                if (awvalid && awready) begin
                    awvalid <= 1'b0;
                    awaddr <= ~a;
                end
                if (wvalid && wready) begin
                    wvalid <= 1'b0;
                    wdata <= ~d;
                end
            end while (!(bvalid && bready) && n < 64);
            resp = bresp;
            bready <= 1'b0;
            if (!(bvalid && bready))
                hung <= 1'b1;
        end
    endtask

    task rd(input [7:0] a, output [31:0] d, output [1:0] resp);
        integer n;
        begin
            @(posedge clk_sys);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
                if (arvalid && arready) begin
                    arvalid <= 1'b0;
                    araddr <= ~a;
                end
            end while (!(rvalid && rready) && n < 64);
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            if (!(rvalid && rready))
                hung <= 1'b1;
        end
    endtask
endmodule

// ---- tb_masked_flag_mux_and_negate_alu.sv ----
`timescale 1ns/1ns
`include "masked_alu_map.vh"

module tb_masked_flag_mux_and_negate_alu;
    // ----------------------------------------
    // clock, bus and instances
    // ----------------------------------------
    localparam [5:0] op_ic = `OP_MASKED_COPY_INVERTED_CARRY;
    localparam [5:0] op_iz = `OP_MASKED_COPY_INVERTED_ZERO_FLAG;
    localparam [5:0] op_zc = `OP_MASKED_COPY_ZERO_FLAG;
    localparam [5:0] op_ng = `OP_ADDITIVE_INVERSE;
    localparam [5:0] op_cs = `OP_CARRY_SELECTED_INVERSE;
    reg         clk_sys = 1'b0;
    reg         reset = 1'b1;
    wire [7:0]  awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0]  wstrb;
    wire [1:0]  bresp, rresp;
    wire        awvalid, awready, wvalid, wready, bvalid, bready;
    wire        arvalid, arready, rvalid, rready, hung;
    integer     err_total = 0;
    integer     cmp_count = 0;
    reg  [31:0] rdat;
    reg  [1:0]  rsp;
    reg  [7:0]  a;

    always #25 clk_sys = ~clk_sys;

    axil_master_model m (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung));

    masked_alu DUT (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task test_done;
        begin
            if (err_total == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task cmp(input string what, input [31:0] exp, input [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    always @(posedge clk_sys) begin
        if (hung === 1'b1) begin
            err_total = err_total + 1;
            test_done;
        end
    end

    // polls status until busy clears; a run that never ends is a mismatch
    task settle(output [31:0] d);
        reg [1:0] r;
        integer   n;
        begin
            n = 0;
            d = 32'h0000_0001;
            while (d[0] !== 1'b0 && n < 20) begin
                m.rd(`OFF_STATUS, d, r);
                n = n + 1;
            end
            if (d[0] !== 1'b0) begin
                err_total = err_total + 1;
                test_done;
            end
        end
    endtask

    // fl and fo are {carry, zero}; eff is {wz, wc, wr, imm}
    task exec(input [5:0] op, input [3:0] eff, input [31:0] src, dst, input [1:0] fl,
              input [31:0] res, input [1:0] fo);
        reg [31:0] d;
        reg [1:0]  r;
        begin
            m.wr(`OFF_DEST, dst, r);
            // a wrong operand shows up if the immediate select is ignored
            m.wr(`OFF_SRC_REG, eff[0] ? ~src : src, r);
            m.wr(`OFF_FLAGS, {30'h0, fl}, r);
            m.wr(`OFF_INSTR, {op, eff, 4'hF, 9'h000, src[8:0]}, r);
            cmp("instr write", {30'h0, `RESP_OKAY}, {30'h0, r});
            m.rd(`OFF_STATUS, d, r);
            cmp("busy", 32'h1, d & 32'h1);
            settle(d);
            cmp("status", {28'h0, eff[1], 3'h2}, d);
            m.rd(`OFF_DEST, d, r);
            cmp("dest", eff[1] ? res : dst, d);
            m.rd(`OFF_FLAGS, d, r);
            cmp("flags", {30'h0, eff[2] ? fo[1] : fl[1], eff[3] ? fo[0] : fl[0]}, d);
            m.rd(`OFF_RESULT, d, r);
            cmp("result", res, d);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        a = `OFF_INSTR;
        repeat (6) begin
            m.rd(a, rdat, rsp);
            cmp("reset value", `RST_WORD, rdat);
            a = a + 8'h04;
        end
        m.wr(`OFF_STATUS, 32'hFFFFFFFF, rsp);
        cmp("status write", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        m.rd(8'h18, rdat, rsp);
        cmp("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        exec(op_ic, 4'hF, 32'h1, 32'h0, 2'h0, 32'h1, 2'h2);
        exec(op_ic, 4'hE, 32'h12345678, 32'hAA552200, 2'h2, 32'hA8412000, 2'h0);
        exec(op_ic, 4'hE, 32'hFFFFFFFF, 32'hAA552200, 2'h2, 32'h0, 2'h1);
        exec(op_iz, 4'hE, 32'h12345678, 32'hAA552200, 2'h0, 32'hBA757678, 2'h2);
        exec(op_iz, 4'hF, 32'h3, 32'h0, 2'h1, 32'h0, 2'h1);
        exec(op_zc, 4'hE, 32'h12345678, 32'hAA552200, 2'h1, 32'hBA757678, 2'h2);
        exec(op_zc, 4'hE, 32'hFFFFFFFF, 32'hAA552200, 2'h0, 32'h0, 2'h1);
        exec(op_ng, 4'hE, 32'hFFFFFFFF, 32'h0, 2'h0, 32'h1, 2'h2);
        exec(op_ng, 4'hE, 32'h80000000, 32'h0, 2'h0, 32'h80000000, 2'h2);
        exec(op_ng, 4'hF, 32'h1FF, 32'h5, 2'h3, 32'hFFFFFE01, 2'h0);
        exec(op_cs, 4'hE, 32'hFFFFFFFF, 32'h0, 2'h0, 32'hFFFFFFFF, 2'h2);
        exec(op_cs, 4'hE, 32'h1, 32'h0, 2'h2, 32'hFFFFFFFF, 2'h0);
        exec(op_cs, 4'hE, 32'h80000001, 32'h0, 2'h2, 32'h7FFFFFFF, 2'h2);
        exec(op_cs, 4'hE, 32'h80000000, 32'h0, 2'h3, 32'h80000000, 2'h2);
        exec(op_ic, 4'h0, 32'h12345678, 32'hAA552200, 2'h2, 32'hA8412000, 2'h0);
        exec(op_ng, 4'hA, 32'h0, 32'h7, 2'h2, 32'h0, 2'h1);
        exec(op_ng, 4'h4, 32'h80000001, 32'h9, 2'h1, 32'h7FFFFFFF, 2'h2);
        // condition never true: skipped, nothing written; writes refused while busy
        m.wr(`OFF_INSTR, {op_ng, 4'hE, 4'h0, 18'h00000}, rsp);
        m.wr(`OFF_DEST, 32'h0, rsp);
        cmp("busy write", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        settle(rdat);
        cmp("skip status", 32'h12, rdat);
        // unknown opcode: flagged illegal, nothing written
        m.wr(`OFF_INSTR, {6'h00, 4'hE, 4'hF, 18'h00000}, rsp);
        settle(rdat);
        cmp("illegal status", 32'h6, rdat);
        m.rd(`OFF_DEST, rdat, rsp);
        cmp("dest kept", 32'h9, rdat);
        test_done;
    end
endmodule
